// ### hdl/csm_bank.sv
// Overview of operation
// - Each channel has a standby bit at its own index; 1 is standby.
// - A standby channel keeps its slot in the output frame.
// - A standby slot is an all-zero header and 24 zero data bits.
// - Standby on channel 0 also turns off the common-mode output.
// - Standby on channel 2 also turns off crystal excitation.
// - Two profiles, A and B, each hold filter type and decimation.
// - Map bits 0, 1, 4, 5 pick profile per channel; 1 is B.
// - Frames are paced at the faster of the two profile rates.
// - Slow channels between results give zero data, repeat bit set.
// - Profile bit 3 picks wideband at 0, sinc5 at 1; resets to 1.
// - Decimation code 0..4 is x32..x512; 5, 6, 7 are x1024.
// - Profile register resets to 0x0D; bits above 3 unused.
module csm_bank
    import csm_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Register port
    input wire csm_bus_t bus_i,
    output logic [7:0] rdata_o,
    // Conversion results from the filters
    input wire logic [NCH-1:0][23:0] res_i,
    // Output frame
    output logic frame_o,
    output csm_slot_t [NCH-1:0] slot_o,
    // Per-channel configuration
    output csm_cfg_t [NCH-1:0] cfg_o,
    output logic [NCH-1:0][23:0] cal_offset_o,
    output logic [NCH-1:0][23:0] cal_gain_o,
    output logic [NCH-1:0][7:0] sync_phase_o,
    // Analog side controls
    output logic common_mode_voltage_output_en_o,
    output logic xtal_exc_en_o,
    output logic [7:0] diag_rx_o,
    output logic [7:0] diag_mux_o,
    output logic [7:0] mod_delay_o,
    output logic [7:0] chop_o
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [7:0] stby_r;
    logic [7:0] prof_a_r;
    logic [7:0] prof_b_r;
    logic [7:0] map_r;
    logic [NCH-1:0][7:0] sync_r;
    logic [7:0] diag_rx_r;
    logic [7:0] diag_mux_r;
    logic [7:0] mod_del_r;
    logic [7:0] chop_r;
    logic [7:0] rd_val;
    logic cal_hit;
    logic [4:0] cal_idx;
    logic [2*NCH-1:0][23:0] cal_w;
    logic [NCH-1:0] sel_b;
    logic pace_frame;
    logic [NCH-1:0] pace_fresh;
    logic [NCH-1:0] fresh_last_r;
    logic cm_en_r;
    logic xtal_en_r;
    csm_cfg_t [NCH-1:0] cfg_nxt;
    csm_cfg_t [NCH-1:0] cfg_r;
    csm_slot_t [NCH-1:0] slot_nxt;
    csm_slot_t [NCH-1:0] slot_r;
    logic frame_r;

    ////////////////////////////////////////////////////////////////////////
    // Write decode

    // Masks keep unused bits at zero, so reads never show junk that
    // software wrote there earlier
    // Standby bits; upper nibble is unused
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            stby_r <= RST_STBY;
        end else if (bus_i.wr && bus_i.addr == ADR_STBY) begin
            stby_r <= bus_i.wdata & MSK_STBY;
        end
    end

    // Profile A: filter bit plus decimation code
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prof_a_r <= RST_PROF;
        end else if (bus_i.wr && bus_i.addr == ADR_PROF_A) begin
            prof_a_r <= bus_i.wdata & MSK_PROF;
        end
    end

    // Same mask as A, so both profiles read back alike
    // Profile B, same layout as A
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prof_b_r <= RST_PROF;
        end else if (bus_i.wr && bus_i.addr == ADR_PROF_B) begin
            prof_b_r <= bus_i.wdata & MSK_PROF;
        end
    end

    // Channel to profile map
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            map_r <= RST_MAP;
        end else if (bus_i.wr && bus_i.addr == ADR_MAP) begin
            map_r <= bus_i.wdata & MSK_MAP;
        end
    end

    // Every bit is meaningful here, so no mask is applied
    // Sync phase offsets, full byte each
    for (genvar c = 0; c < NCH; c++) begin : g_sync
        always_ff @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                sync_r[c] <= RST_SYNC;
            end else if (bus_i.wr && bus_i.addr == ADR_SYNC[c]) begin
                sync_r[c] <= bus_i.wdata;
            end
        end
    end

    // Fields sit in both nibbles; the gaps between them stay zero
    // Diagnostic receive and mux selects
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            diag_rx_r <= RST_DIAG;
            diag_mux_r <= RST_DIAG;
        end else if (bus_i.wr) begin
            if (bus_i.addr == ADR_DIAG_RX) begin
                diag_rx_r <= bus_i.wdata & MSK_DIAG_RX;
            end
            if (bus_i.addr == ADR_DIAG_MUX) begin
                diag_mux_r <= bus_i.wdata & MSK_DIAG_MUX;
            end
        end
    end

    // Only the low nibble is kept; the upper half is unused
    // Modulator delay and chopping controls
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mod_del_r <= RST_MOD_DEL;
            chop_r <= RST_CHOP;
        end else if (bus_i.wr) begin
            if (bus_i.addr == ADR_MOD_DEL) begin
                mod_del_r <= bus_i.wdata & MSK_NIBBLE;
            end
            if (bus_i.addr == ADR_CHOP) begin
                chop_r <= bus_i.wdata & MSK_NIBBLE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Calibration byte decode

    // No byte is latched: a value written half way is seen by the
    // filters at once, so software writes calibration while idle
    // Offsets take words 0..3, gains 4..7, three bytes each
    always_comb begin
        cal_hit = 1'b0;
        cal_idx = '0;
        for (int c = 0; c < NCH; c++) begin
            for (int b = 0; b < CAL_BYTES; b++) begin
                if (bus_i.addr == ADR_OFS[c] + 8'(b)) begin
                    cal_hit = 1'b1;
                    cal_idx = 5'(CAL_BYTES * c + b);
                end
                if (bus_i.addr == ADR_GAIN[c] + 8'(b)) begin
                    cal_hit = 1'b1;
                    cal_idx = 5'(CAL_BYTES * (c + NCH) + b);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path

    // The mux feeds the store's output flop, one cycle late, so no
    // decode logic sits between the registers and the read port
    // Unmapped and reserved addresses read zero
    always_comb begin
        rd_val = '0;
        case (bus_i.addr)
            ADR_STBY: rd_val = stby_r;
            ADR_PROF_A: rd_val = prof_a_r;
            ADR_PROF_B: rd_val = prof_b_r;
            ADR_MAP: rd_val = map_r;
            ADR_SYNC[0]: rd_val = sync_r[0];
            ADR_SYNC[1]: rd_val = sync_r[1];
            ADR_SYNC[2]: rd_val = sync_r[2];
            ADR_SYNC[3]: rd_val = sync_r[3];
            ADR_DIAG_RX: rd_val = diag_rx_r;
            ADR_DIAG_MUX: rd_val = diag_mux_r;
            ADR_MOD_DEL: rd_val = mod_del_r;
            ADR_CHOP: rd_val = chop_r;
            ADR_STATUS: begin
                rd_val[NCH-1:0] = fresh_last_r;
                rd_val[ST_CM_BIT] = cm_en_r;
                rd_val[ST_XTAL_BIT] = xtal_en_r;
            end
            default: rd_val = '0;
        endcase
    end

    // Calibration store; its read flop also returns the other registers
    csm_cal_mem u_cal (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(bus_i.wr),
        .rd_i(bus_i.rd),
        .hit_i(cal_hit),
        .idx_i(cal_idx),
        .wdata_i(bus_i.wdata),
        .alt_i(rd_val),
        .rdata_o(rdata_o),
        .cal_o(cal_w)
    );

    ////////////////////////////////////////////////////////////////////////
    // Profile selection

    // Each channel copies its profile into its own flop; the filters
    // see a new setting one cycle after the write
    // Pick each channel's profile from its map bit
    for (genvar c = 0; c < NCH; c++) begin : g_sel
        assign sel_b[c] = map_r[MAP_BIT[c]];
    end

    // Configuration handed to the filters, one flop per channel
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            cfg_nxt[c].standby = stby_r[c];
            if (sel_b[c]) begin
                cfg_nxt[c].sinc5 = prof_b_r[PROF_FILT_BIT];
                cfg_nxt[c].dec = prof_b_r[2:0];
            end else begin
                cfg_nxt[c].sinc5 = prof_a_r[PROF_FILT_BIT];
                cfg_nxt[c].dec = prof_a_r[2:0];
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cfg_r <= '0;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power side effects

    // Enables follow the standby bits one cycle late; software must
    // not expect the pin to drop in the cycle of the write
    // Common-mode buffer lives in channel 0, crystal driver in channel 2
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cm_en_r <= 1'b1;
            xtal_en_r <= 1'b1;
        end else begin
            cm_en_r <= ~stby_r[0];
            xtal_en_r <= ~stby_r[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame pacing and slot build

    // The counter is not restarted on a rate change; every frame still
    // falls on a multiple of 32 cycles, so frames never crowd
    // Decode shared for both profiles lives in the pacer
    csm_frame_pace u_pace (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .dec_a_i(prof_a_r[2:0]),
        .dec_b_i(prof_b_r[2:0]),
        .sel_b_i(sel_b),
        .frame_o(pace_frame),
        .fresh_o(pace_fresh)
    );

    // Stale slots keep their channel id so the host can still tell
    // them apart while the data word is zero
    // Slot content: standby zero, stale repeated, else live result
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            slot_nxt[c] = '0;
            if (stby_r[c]) begin
                slot_nxt[c] = '0;
            end else if (pace_fresh[c]) begin
                slot_nxt[c].hdr[2:0] = 3'(c);
                slot_nxt[c].data = res_i[c];
            end else begin
                slot_nxt[c].hdr[2:0] = 3'(c);
                slot_nxt[c].hdr[HDR_REPEAT_BIT] = 1'b1;
            end
        end
    end

    // Every slot updates on every frame, so positions never shift
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            slot_r <= '0;
            fresh_last_r <= '0;
        end else if (pace_frame) begin
            slot_r <= slot_nxt;
            fresh_last_r <= pace_fresh & ~stby_r[NCH-1:0];
        end
    end

    // Delayed by one flop to line up with the slot update
    // Frame strobe stands one cycle beside the new slots
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            frame_r <= 1'b0;
        end else begin
            frame_r <= pace_frame;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flops

    // Plain wires from flops; no logic between register and port
    assign frame_o = frame_r;
    assign slot_o = slot_r;
    assign cfg_o = cfg_r;
    assign cal_offset_o = cal_w[NCH-1:0];
    assign cal_gain_o = cal_w[2*NCH-1:NCH];
    assign sync_phase_o = sync_r;
    assign common_mode_voltage_output_en_o = cm_en_r;
    assign xtal_exc_en_o = xtal_en_r;
    assign diag_rx_o = diag_rx_r;
    assign diag_mux_o = diag_mux_r;
    assign mod_delay_o = mod_del_r;
    assign chop_o = chop_r;

endmodule // csm_bank

// ### hdl/csm_cal_mem.sv
module csm_cal_mem
    import csm_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Byte access
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic hit_i,
    input wire logic [4:0] idx_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] alt_i,
    output logic [7:0] rdata_o,
    // Assembled values, offsets 0..3 then gains 0..3
    output logic [2*NCH-1:0][23:0] cal_o
);

    logic [7:0] mem_r [CAL_WORDS];

    // Byte store; cleared at reset so offsets start at zero
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < CAL_WORDS; i++) begin
                mem_r[i] <= RST_CAL;
            end
        end else if (wr_i && hit_i) begin
            mem_r[idx_i] <= wdata_i;
        end
    end

    // Read port also carries the bank's other registers out of one flop
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            rdata_o <= hit_i ? mem_r[idx_i] : alt_i;
        end
    end

    // Most significant byte first
    for (genvar k = 0; k < 2 * NCH; k++) begin : g_word
        assign cal_o[k] = {mem_r[CAL_BYTES*k], mem_r[CAL_BYTES*k+1],
                           mem_r[CAL_BYTES*k+2]};
    end

endmodule // csm_cal_mem

// ### hdl/csm_frame_pace.sv
module csm_frame_pace
    import csm_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Profile rates and channel mapping
    input wire logic [2:0] dec_a_i,
    input wire logic [2:0] dec_b_i,
    input wire logic [NCH-1:0] sel_b_i,
    // Pacing
    output logic frame_o,
    output logic [NCH-1:0] fresh_o
);

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] mask_a;
    logic [CNT_W-1:0] mask_b;
    logic [CNT_W-1:0] mask_fast;

    assign mask_a = csm_dec_mask(dec_a_i);
    assign mask_b = csm_dec_mask(dec_b_i);
    // Masks are 2^n-1, so the AND is the faster of the two
    assign mask_fast = mask_a & mask_b;

    // Free running period counter, wraps at the slowest ratio
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // Frame at the fast rate; each channel fresh at its own rate
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            frame_o <= 1'b0;
            fresh_o <= '0;
        end else begin
            frame_o <= (cnt_r & mask_fast) == mask_fast;
            for (int c = 0; c < NCH; c++) begin
                fresh_o[c] <= sel_b_i[c] ? ((cnt_r & mask_b) == mask_b)
                                         : ((cnt_r & mask_a) == mask_a);
            end
        end
    end

endmodule // csm_frame_pace

// ### hdl/csm_pkg.sv
package csm_pkg;

    // Channel count and widths
    localparam int NCH = 4;
    localparam int CNT_W = 10;
    localparam int CAL_BYTES = 3;
    localparam int CAL_WORDS = 24;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] ADR_STBY = 8'h00;
    localparam logic [7:0] ADR_PROF_A = 8'h01;
    localparam logic [7:0] ADR_PROF_B = 8'h02;
    localparam logic [7:0] ADR_MAP = 8'h03;
    localparam logic [7:0] ADR_OFS [NCH] = '{8'h1E, 8'h21, 8'h2A, 8'h2D};
    localparam logic [7:0] ADR_GAIN [NCH] = '{8'h36, 8'h39, 8'h42, 8'h45};
    localparam logic [7:0] ADR_SYNC [NCH] = '{8'h4E, 8'h4F, 8'h52, 8'h53};
    localparam logic [7:0] ADR_DIAG_RX = 8'h56;
    localparam logic [7:0] ADR_DIAG_MUX = 8'h57;
    localparam logic [7:0] ADR_MOD_DEL = 8'h58;
    localparam logic [7:0] ADR_CHOP = 8'h59;
    localparam logic [7:0] ADR_STATUS = 8'h5F;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] RST_STBY = 8'h00;
    localparam logic [7:0] RST_PROF = 8'h0D;
    localparam logic [7:0] RST_MAP = 8'h00;
    localparam logic [7:0] RST_SYNC = 8'h00;
    localparam logic [7:0] RST_DIAG = 8'h00;
    localparam logic [7:0] RST_MOD_DEL = 8'h02;
    localparam logic [7:0] RST_CHOP = 8'h0A;
    localparam logic [7:0] RST_CAL = 8'h00;

    // Implemented bits; the rest are dropped on write, read as zero
    localparam logic [7:0] MSK_STBY = 8'h0F;
    localparam logic [7:0] MSK_PROF = 8'h0F;
    localparam logic [7:0] MSK_MAP = 8'h33;
    localparam logic [7:0] MSK_DIAG_RX = 8'h33;
    localparam logic [7:0] MSK_DIAG_MUX = 8'h77;
    localparam logic [7:0] MSK_NIBBLE = 8'h0F;

    // Field positions
    localparam int PROF_FILT_BIT = 3;
    localparam int MAP_BIT [NCH] = '{0, 1, 4, 5};
    localparam int HDR_REPEAT_BIT = 4;
    localparam int ST_CM_BIT = 6;
    localparam int ST_XTAL_BIT = 7;

    ////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } csm_bus_t;

    typedef struct packed {
        logic standby;
        logic sinc5;
        logic [2:0] dec;
    } csm_cfg_t;

    typedef struct packed {
        logic [7:0] hdr;
        logic [23:0] data;
    } csm_slot_t;

    // Decimation code to period mask (ratio minus one)
    function automatic logic [CNT_W-1:0] csm_dec_mask(input logic [2:0] code);
        unique case (code)
            3'h0: csm_dec_mask = 10'h01F;
            3'h1: csm_dec_mask = 10'h03F;
            3'h2: csm_dec_mask = 10'h07F;
            3'h3: csm_dec_mask = 10'h0FF;
            3'h4: csm_dec_mask = 10'h1FF;
            default: csm_dec_mask = 10'h3FF;
        endcase
    endfunction

endpackage

// ### tb/csm_bank_assertions.sv
module csm_bank_chk
    import csm_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Watched ports
    input wire csm_bus_t bus_i,
    input wire logic [7:0] rdata_o,
    input wire logic frame_o,
    input wire csm_slot_t [NCH-1:0] slot_o,
    input wire csm_cfg_t [NCH-1:0] cfg_o,
    input wire logic common_mode_voltage_output_en_o,
    input wire logic xtal_exc_en_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    ////////////////////////////////////////////////////////////////////////
    // Side controls follow the standby bits at all times
    chk_cm_follows: assert property (
        common_mode_voltage_output_en_o == !cfg_o[0].standby)
        else $error("common-mode enable wrong");
    chk_xtal_follows: assert property (
        xtal_exc_en_o == !cfg_o[2].standby)
        else $error("crystal enable wrong");
    // Settled standby gives an empty slot
    chk_stby_slot: assert property (
        frame_o && cfg_o[3].standby && $past(cfg_o[3].standby, 2)
        |-> slot_o[3] == '0)
        else $error("standby slot not empty");
    // Read data one cycle after the strobe
    chk_stby_read: assert property (
        bus_i.rd && bus_i.addr == ADR_STBY |=> rdata_o ==
        {4'h0, cfg_o[3].standby, cfg_o[2].standby, cfg_o[1].standby,
        cfg_o[0].standby})
        else $error("standby readback wrong");
    chk_hole_read: assert property (
        bus_i.rd && bus_i.addr == 8'h30 |=> rdata_o == 8'h00)
        else $error("reserved read not zero");
    chk_prof_upper: assert property (
        bus_i.rd && bus_i.addr == ADR_PROF_A |=> rdata_o[7:4] == 4'h0)
        else $error("profile upper bits not zero");
    // Frame strobe is a single pulse, spaced by the fastest rate
    chk_frame_pulse: assert property (
        frame_o |=> !frame_o [*8])
        else $error("frame strobe too long");
    chk_period_32: assert property (
        (frame_o && cfg_o[0].dec == 3'h0) ##32 (cfg_o[0].dec == 3'h0)
        |-> frame_o)
        else $error("x32 frame spacing wrong");
    chk_repeat_zero: assert property (
        frame_o && slot_o[1].hdr[HDR_REPEAT_BIT] |-> slot_o[1].data == '0)
        else $error("repeat slot carries data");

    // Main scenarios reached
    cov_repeat: cover property (frame_o && slot_o[1].hdr[HDR_REPEAT_BIT]);
    cov_stby: cover property (frame_o && cfg_o[3].standby);
    cov_read: cover property (bus_i.rd && bus_i.addr == ADR_STBY);
endmodule // csm_bank_chk

bind csm_bank csm_bank_chk i_chk (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .bus_i(bus_i),
    .rdata_o(rdata_o),
    .frame_o(frame_o),
    .slot_o(slot_o),
    .cfg_o(cfg_o),
    .common_mode_voltage_output_en_o(common_mode_voltage_output_en_o),
    .xtal_exc_en_o(xtal_exc_en_o)
);

// ### tb/csm_host.sv
module csm_host
    import csm_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Register port
    output csm_bus_t bus_o,
    input wire logic [7:0] rdata_i
);
    timeunit 1ns;
    timeprecision 1ps;

    // Outside use of the common-mode pin or a crystal
    logic cm_used = 1'b0;
    logic xtal_used = 1'b0;

    initial bus_o = '0;

    ////////////////////////////////////////////////////////////////////////
    // Write; idle lines show the inverse so stale values never match
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == ADR_STBY) begin
            v[0] = v[0] & ~cm_used;
            v[2] = v[2] & ~xtal_used;
        end
        @(posedge clk_i);
        bus_o <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus_o <= '{addr: ~a, wdata: ~v, wr: 1'b0, rd: 1'b0};
    endtask

    // Read; data taken 1 ns after the edge that ends the strobe, not on the edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        bus_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus_o <= '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
        #1;
        d = rdata_i;
    endtask
endmodule // csm_host

// ### tb/test_csm_bank.sv
module test_csm_bank
    import csm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        logic [7:0] a;
        logic [7:0] rst;
        logic [7:0] wd;
        logic [7:0] exp;
    } csm_row_t;

    localparam int LIMIT = 40000;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    csm_bus_t bus;
    logic [7:0] rdata, d;
    logic [NCH-1:0][23:0] res;
    logic frame, cm_en, xtal_en;
    logic [7:0] drx, dmux, mdel, chp;
    logic [NCH-1:0][7:0] sph;
    csm_slot_t [NCH-1:0] slot;
    csm_cfg_t [NCH-1:0] cfg;
    logic [NCH-1:0][23:0] ofs, gain;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;
    int n, reps;
    // Address, reset value, written value, read back value
    csm_row_t rows [10] = '{
        '{ADR_STBY, 8'h00, 8'hF5, 8'h05}, '{ADR_PROF_A, 8'h0D, 8'hF2, 8'h02},
        '{ADR_MAP, 8'h00, 8'hFF, 8'h33}, '{ADR_OFS[3], 8'h00, 8'hA5, 8'hA5},
        '{ADR_SYNC[1], 8'h00, 8'h5A, 8'h5A},
        '{ADR_DIAG_RX, 8'h00, 8'hFF, 8'h33},
        '{ADR_DIAG_MUX, 8'h00, 8'hFF, 8'h77},
        '{ADR_MOD_DEL, 8'h02, 8'hFF, 8'h0F}, '{ADR_CHOP, 8'h0A, 8'hFF, 8'h0F},
        '{8'h30, 8'h00, 8'hFF, 8'h00}};

    csm_host i_host (.clk_i(clk_i), .bus_o(bus), .rdata_i(rdata));

    csm_bank i_dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus),
        .rdata_o(rdata), .res_i(res), .frame_o(frame), .slot_o(slot),
        .cfg_o(cfg), .cal_offset_o(ofs), .cal_gain_o(gain),
        .sync_phase_o(sph), .common_mode_voltage_output_en_o(cm_en),
        .xtal_exc_en_o(xtal_en), .diag_rx_o(drx), .diag_mux_o(dmux),
        .mod_delay_o(mdel), .chop_o(chp));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] seen,
            input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic conclude();
        if (errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Derived outputs lag the register by one edge
    task automatic settle();
        repeat (3) @(posedge clk_i);
        #1;
    endtask

    // Bounded wait; frame stands one cycle so each cycle is looked at
    task automatic wait_frame(output int k);
        k = 0;
        do begin
            @(posedge clk_i);
            #1;
            k++;
        end while (frame !== 1'b1 && k < 2100);
    endtask

    initial forever #2.5 clk_i = ~clk_i;

    // Hang guard
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            errors++;
            conclude();
        end
    end

    initial begin
        for (int i = 0; i < NCH; i++)
            res[i] <= 24'h5A_0010 + 24'(i);
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        settle();
        check("cfg0", cfg[0], 5'h0D);
        check("cm out", cm_en, 1'b1);
        check("xtal", xtal_en, 1'b1);
        // Reset values, masks and holes
        foreach (rows[i]) begin
            i_host.rd(rows[i].a, d);
            check("reset", d, rows[i].rst);
            i_host.wr(rows[i].a, rows[i].wd);
            i_host.rd(rows[i].a, d);
            check("readback", d, rows[i].exp);
        end
        settle();
        check("sync1", sph[1], 8'h5A);
        check("diag rx", drx, 8'h33);
        check("diag mux", dmux, 8'h77);
        check("mod delay", mdel, 8'h0F);
        check("chop", chp, 8'h0F);
        check("stby", {cfg[3].standby, cfg[2].standby, cfg[1].standby,
            cfg[0].standby}, 4'h5);
        check("cm off", cm_en, 1'b0);
        check("xtal off", xtal_en, 1'b0);
        i_host.wr(ADR_STBY, 8'h00);
        i_host.wr(ADR_MAP, 8'h00);
        // Every decimation code, filter bit toggled alongside
        for (int c = 0; c < 8; c++) begin
            i_host.wr(ADR_PROF_A, {4'h0, c[0], c[2:0]});
            wait_frame(n);
            wait_frame(n);
            wait_frame(n);
            check("period", n, c > 4 ? 1024 : 32 << c);
            check("filter", cfg[0].sinc5, c[0]);
        end
        // Mixed rates, channel 1 on the slower profile, channel 3 idle
        i_host.wr(ADR_PROF_A, 8'h08);
        i_host.wr(ADR_PROF_B, 8'h01);
        i_host.wr(ADR_MAP, 8'h02);
        i_host.wr(ADR_STBY, 8'h08);
        wait_frame(n);
        wait_frame(n);
        reps = 0;
        for (int f = 0; f < 4; f++) begin
            wait_frame(n);
            check("pace", n, 32);
            check("slot0", slot[0].data, res[0]);
            check("slot2", slot[2].data, res[2]);
            check("slot3", slot[3], 32'h0000_0000);
            if (slot[1].hdr[HDR_REPEAT_BIT] === 1'b1) begin
                reps++;
                check("stale", slot[1].data, 24'h00_0000);
            end else
                check("fresh", slot[1].data, res[1]);
        end
        check("repeats", reps, 2);
        // Status: both enables up, ch0 and ch2 fresh, ch3 idle
        i_host.rd(ADR_STATUS, d);
        check("status", d, 8'hC5 | {6'h00,
            ~slot[1].hdr[HDR_REPEAT_BIT], 1'h0});
        // Outside users hold channels 0 and 2 up whatever is written
        i_host.cm_used = 1'b1;
        i_host.xtal_used = 1'b1;
        i_host.wr(ADR_STBY, 8'h0D);
        settle();
        check("cm kept", cm_en, 1'b1);
        check("xtal kept", xtal_en, 1'b1);
        check("stby3", cfg[3].standby, 1'b1);
        // Three-byte calibration, high byte first
        i_host.wr(ADR_GAIN[2], 8'h12);
        i_host.wr(ADR_GAIN[2] + 8'h01, 8'h34);
        i_host.wr(ADR_GAIN[2] + 8'h02, 8'h56);
        i_host.wr(ADR_OFS[2] + 8'h02, 8'h77);
        settle();
        check("gain2", gain[2], 24'h12_3456);
        check("ofs2", ofs[2], 24'h00_0077);
        // Reset again in mid-run
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        i_host.rd(ADR_STBY, d);
        check("stby rst", d, 8'h00);
        i_host.rd(ADR_PROF_A, d);
        check("prof rst", d, 8'h0D);
        check("mod delay rst", mdel, 8'h02);
        check("chop rst", chp, 8'h0A);
        check("sync rst", sph[1], 8'h00);
        check("gain rst", gain[2], 24'h00_0000);
        check("cm rst", cm_en, 1'b1);
        conclude();
    end
endmodule // test_csm_bank
